// [rtl/spm_pkg.sv]
/*
 Constants for the status pin routing and memory commit register slice.
 Assumes the serial port decoder delivers one 16-bit register access per strobe on mclk.
*/
// How it works
// - Bits 11-8 pick status pin zero source
// - Bits 7-4 pick pin four, reset 5h
// - Bits 3-0 pick pin one, reset 3h
// - Bypass bit skips checksum after reset load
// - Power-on load with page chosen checks anyway
// - Bit 14 starts checksum recompute, self-clears
// - Bit 13 loads chosen page into registers
// - Bit 12 stores registers into chosen page
// - Bit 11 picks page for both commits
// - Power register channel bits, reset 54h
// - Channel bit one powers channel down
package spm_pkg;
	// ----------------------------------------
	// Register map and widths.
	// ----------------------------------------
	localparam int DATA_W = 16; // Register data width.
	localparam int ADDR_W = 8; // Register address width.
	localparam logic [7:0] ADDR_PIN_SEL = 8'h02; // Status pin source select register.
	localparam logic [7:0] ADDR_COMMIT = 8'h03; // Memory commit control register.
	localparam logic [7:0] ADDR_POWER = 8'h04; // Channel power-down register.
	localparam logic [15:0] PIN_SEL_RESET = 16'h0053; // Pin zero 0h, pin four 5h, pin one 3h.
	localparam logic [15:0] COMMIT_RESET = 16'h0000; // All commit bits idle.
	localparam logic [15:0] POWER_RESET = 16'h0054; // Reserved bits 6, 4 and 2 set.
	localparam logic [15:0] COMMIT_STORE_MASK = 16'h8FFF; // Bits held as plain storage.
	localparam logic [15:0] ZERO_WORD = 16'h0000; // Answer for unmapped reads.
	// ----------------------------------------
	// Field positions.
	// ----------------------------------------
	localparam int SEL_W = 4; // Width of one source selector.
	localparam int PIN0_LSB = 8; // Pin zero selector low bit.
	localparam int PIN4_LSB = 4; // Pin four selector low bit.
	localparam int PIN1_LSB = 0; // Pin one selector low bit.
	localparam int BIT_DISABLE_CRC = 15; // Checksum bypass.
	localparam int BIT_UPDATE_CRC = 14; // Checksum recompute command.
	localparam int BIT_MEM_TO_REG = 13; // Page to register command.
	localparam int BIT_REG_TO_MEM = 12; // Register to page command.
	localparam int BIT_COMMIT_PAGE = 11; // Page for commits.
	localparam int BIT_RSVD_SC_HI = 2; // Self-clearing reserved pair, high bit.
	localparam int BIT_RSVD_SC_LO = 1; // Self-clearing reserved pair, low bit.
	localparam int BIT_CH1 = 1; // Channel one power-off bit.
	localparam int BIT_CH2 = 3; // Channel two power-off bit.
	localparam int BIT_CH3 = 5; // Channel three power-off bit.
	localparam int BIT_CH4 = 7; // Channel four power-off bit.
	// ----------------------------------------
	// Status source codes; codes above the last one drive low.
	// ----------------------------------------
	localparam int NUM_SOURCES = 15; // Codes 0h to Eh.
	localparam logic [3:0] SRC_LOCK = 4'h0; // Lock indication.
	localparam logic [3:0] SRC_CONFIGURATION_FINISHED = 4'h3; // Configuration done.
	localparam logic [3:0] SRC_MEMORY_BUSY = 4'h5; // Memory busy.
	localparam int SYNC_STAGES = 3; // Flops on every pin input.
	// ----------------------------------------
	// Memory engine operations; the code is also the request priority, low first.
	// ----------------------------------------
	localparam int NUM_OPS = 4; // Number of operation kinds.
	localparam int OP_W = 2; // Operation code width.
	localparam logic [1:0] OP_LOAD_CFG = 2'h0; // Reset or power-on configuration load.
	localparam logic [1:0] OP_MEM_TO_REG = 2'h1; // Page to registers.
	localparam logic [1:0] OP_REG_TO_MEM = 2'h2; // Registers to page.
	localparam logic [1:0] OP_CRC = 2'h3; // Checksum recompute.
	typedef enum {SEQ_IDLE, SEQ_LAUNCH, SEQ_WAIT} spm_seq_state_type; // Sequencer states.
endpackage : spm_pkg

// [rtl/spm_pin_router.sv]
/*
 Synchronises the internal status sources and routes one onto each status pin.
 Assumes the sources come from other clock domains; clock sources are only sampled.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_pin_router #(
	parameter int NSRC = spm_pkg::NUM_SOURCES,
	parameter int SW = spm_pkg::SEL_W,
	parameter int NPIN = 3
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NSRC-1:0] statusSources,
	input wire logic [NPIN*SW-1:0] pinSel,
	output logic [NPIN-1:0] pinOut
);
	// ----------------------------------------
	// Input synchroniser with agreement filter.
	// ----------------------------------------
	logic [NSRC-1:0] sync1_r; // First stage, read only by the second.
	logic [NSRC-1:0] sync2_r; // Second stage.
	logic [NSRC-1:0] sync3_r; // Third stage.
	logic [NSRC-1:0] filt_r; // Accepted level of each source.

	// A change is accepted only once stages two and three agree.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			filt_r <= '0;
		end
		else
		begin
			sync1_r <= statusSources;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= (~(sync2_r ^ sync3_r) & sync2_r) | ((sync2_r ^ sync3_r) & filt_r);
		end
	end

	// Undefined codes drive low so a stray code never shows a random level.
	function automatic logic pickSource(input logic [NSRC-1:0] v, input logic [SW-1:0] c);
		if (int'(c) < NSRC)
			return v[c];
		return 1'b0;
	endfunction : pickSource

	// ----------------------------------------
	// One registered selector per pin.
	// ----------------------------------------
	for (genvar g = 0; g < NPIN; g++)
	begin : gPin
		logic pinQ_r; // Registered pin level.
		// Each pin has its own decode and one register, which keeps all pins equally delayed.
		always_ff @(posedge mclk)
		begin
			if (!rst_n)
				pinQ_r <= 1'b0;
			else
				pinQ_r <= pickSource(filt_r, pinSel[g*SW +: SW]);
		end
		assign pinOut[g] = pinQ_r;
	end
endmodule : spm_pin_router
`default_nettype wire

// [rtl/spm_mem_sequencer.sv]
/*
 Issues one memory engine operation at a time, by fixed priority, and reports acceptance.
 Assumes the engine raises its busy level within one cycle after seeing the start pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_mem_sequencer #(
	parameter int NREQ = spm_pkg::NUM_OPS,
	parameter int OW = spm_pkg::OP_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NREQ-1:0] req,
	input wire logic [NREQ-1:0] reqPage,
	input wire logic [NREQ-1:0] reqSkip,
	input wire logic memBusy,
	output logic [NREQ-1:0] grant,
	output logic memStart,
	output logic [OW-1:0] memOp,
	output logic memPage,
	output logic memSkipCrc,
	output logic seqIdle
);
	spm_pkg::spm_seq_state_type state_r; // Launch state.

	// Lowest set index wins.
	function automatic logic [OW-1:0] firstIndex(input logic [NREQ-1:0] r);
		logic [OW-1:0] idx;
		idx = '0;
		for (int i = NREQ - 1; i >= 0; i--)
			if (r[i])
				idx = OW'(i);
		return idx;
	endfunction : firstIndex

	assign seqIdle = (state_r == spm_pkg::SEQ_IDLE);

	// ----------------------------------------
	// Launch control; the LAUNCH cycle covers the engine's busy latency.
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_r <= spm_pkg::SEQ_IDLE;
			grant <= '0;
			memStart <= 1'b0;
			memOp <= '0;
			memPage <= 1'b0;
			memSkipCrc <= 1'b0;
		end
		else
		begin
			grant <= '0;
			memStart <= 1'b0;
			case (state_r)
				spm_pkg::SEQ_IDLE:
				begin
					// Never start while the engine is still busy from elsewhere.
					if ((|req) && !memBusy)
					begin
						grant <= {{(NREQ-1){1'b0}}, 1'b1} << firstIndex(req);
						memStart <= 1'b1;
						memOp <= firstIndex(req);
						memPage <= reqPage[firstIndex(req)];
						memSkipCrc <= reqSkip[firstIndex(req)];
						state_r <= spm_pkg::SEQ_LAUNCH;
					end
				end
				spm_pkg::SEQ_LAUNCH:
					state_r <= spm_pkg::SEQ_WAIT;
				spm_pkg::SEQ_WAIT:
				begin
					if (!memBusy)
						state_r <= spm_pkg::SEQ_IDLE;
				end
				default:
					state_r <= spm_pkg::SEQ_IDLE;
			endcase
		end
	end
endmodule : spm_mem_sequencer
`default_nettype wire

// [rtl/spm_regs_top.sv]
/*
 Status pin source select, memory commit control and channel power-down registers.
 Assumes a serial port decoder on mclk presents single-cycle read and write strobes,
 and a memory engine on mclk that answers start pulses with a busy level.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_regs_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [spm_pkg::ADDR_W-1:0] regAddr,
	input wire logic [spm_pkg::DATA_W-1:0] regWrData,
	output logic [spm_pkg::DATA_W-1:0] regRdData,
	input wire logic [spm_pkg::NUM_SOURCES-1:0] statusSources,
	input wire logic externalPageSelectPin,
	input wire logic resetLoadReq,
	input wire logic porLoadReq,
	input wire logic pageChosen,
	input wire logic memBusy,
	output logic memStart,
	output logic [spm_pkg::OP_W-1:0] memOp,
	output logic memPage,
	output logic memSkipCrc,
	output logic statusPinZero,
	output logic statusPinOne,
	output logic statusPinFour,
	output logic channel1PowerOff,
	output logic channel2PowerOff,
	output logic channel3PowerOff,
	output logic channel4PowerOff
);
	// ----------------------------------------
	// Storage and decode.
	// ----------------------------------------
	logic [15:0] pinSel_r; // Status pin source selectors.
	logic [15:0] commitStore_r; // Plain bits of the commit register, command bits held apart.
	logic [15:0] powerReg_r; // Channel power-down register.
	logic crcPend_r; // Checksum recompute waiting for the engine.
	logic m2rPend_r; // Page to register waiting.
	logic r2mPend_r; // Register to page waiting.
	logic loadPend_r; // Configuration load waiting.
	logic loadSkip_r; // Checksum bypass decided for the waiting load.
	logic [2:0] pageSync_r; // Page pin synchroniser; stage 0 feeds stage 1 only.
	logic pagePin_r; // Accepted page pin level.
	logic [15:0] rdData_r; // Registered read answer.
	logic wrPinSel; // Write to the selector register.
	logic wrCommit; // Write to the commit register.
	logic wrPower; // Write to the power register.
	logic [3:0] reqVec; // Pending operations in priority order.
	logic [3:0] reqPage; // Page for each operation.
	logic [3:0] reqSkip; // Bypass for each operation.
	logic [3:0] grant; // One-cycle acceptance from the sequencer.
	logic seqIdle; // Sequencer free to launch.
	logic [2:0] pinOut; // Routed pins: zero, one, four.

	assign wrPinSel = regWrEn && (regAddr == spm_pkg::ADDR_PIN_SEL);
	assign wrCommit = regWrEn && (regAddr == spm_pkg::ADDR_COMMIT);
	assign wrPower = regWrEn && (regAddr == spm_pkg::ADDR_POWER);

	// ----------------------------------------
	// Selector and power registers.
	// ----------------------------------------
	// Reserved bits are kept as written so read-back matches what software stored.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			pinSel_r <= spm_pkg::PIN_SEL_RESET;
		else if (wrPinSel)
			pinSel_r <= regWrData;
	end

	// The channel outputs come straight from these flops.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			powerReg_r <= spm_pkg::POWER_RESET;
		else if (wrPower)
			powerReg_r <= regWrData;
	end

	assign channel1PowerOff = powerReg_r[spm_pkg::BIT_CH1];
	assign channel2PowerOff = powerReg_r[spm_pkg::BIT_CH2];
	assign channel3PowerOff = powerReg_r[spm_pkg::BIT_CH3];
	assign channel4PowerOff = powerReg_r[spm_pkg::BIT_CH4];

	// ----------------------------------------
	// Commit register plain bits.
	// ----------------------------------------
	// Reserved bits 2-1 self-clear one cycle after a write; the others simply store.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			commitStore_r <= spm_pkg::COMMIT_RESET;
		else if (wrCommit)
			commitStore_r <= regWrData & spm_pkg::COMMIT_STORE_MASK;
		else
		begin
			commitStore_r[spm_pkg::BIT_RSVD_SC_HI] <= 1'b0;
			commitStore_r[spm_pkg::BIT_RSVD_SC_LO] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Command bits; a new write wins over the acceptance in the same cycle.
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			crcPend_r <= 1'b0;
		else if (wrCommit && regWrData[spm_pkg::BIT_UPDATE_CRC])
			crcPend_r <= 1'b1;
		else if (grant[spm_pkg::OP_CRC])
			crcPend_r <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			m2rPend_r <= 1'b0;
		else if (wrCommit && regWrData[spm_pkg::BIT_MEM_TO_REG])
			m2rPend_r <= 1'b1;
		else if (grant[spm_pkg::OP_MEM_TO_REG])
			m2rPend_r <= 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			r2mPend_r <= 1'b0;
		else if (wrCommit && regWrData[spm_pkg::BIT_REG_TO_MEM])
			r2mPend_r <= 1'b1;
		else if (grant[spm_pkg::OP_REG_TO_MEM])
			r2mPend_r <= 1'b0;
	end

	// ----------------------------------------
	// Configuration load after a reset event.
	// ----------------------------------------
	// A power-on load still checks the memory when a page is chosen; a later reset
	// follows the bypass bit alone. Power-on wins when both arrive together.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			loadPend_r <= 1'b0;
			loadSkip_r <= 1'b0;
		end
		else if (porLoadReq)
		begin
			loadPend_r <= 1'b1;
			loadSkip_r <= commitStore_r[spm_pkg::BIT_DISABLE_CRC] && !pageChosen;
		end
		else if (resetLoadReq)
		begin
			loadPend_r <= 1'b1;
			loadSkip_r <= commitStore_r[spm_pkg::BIT_DISABLE_CRC];
		end
		else if (grant[spm_pkg::OP_LOAD_CFG])
			loadPend_r <= 1'b0;
	end

	// The page pin is a board strap; it is filtered like every other pin input.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			pageSync_r <= '0;
			pagePin_r <= 1'b0;
		end
		else
		begin
			pageSync_r <= {pageSync_r[1:0], externalPageSelectPin};
			if (pageSync_r[1] == pageSync_r[2])
				pagePin_r <= pageSync_r[2];
		end
	end

	// ----------------------------------------
	// Engine requests.
	// ----------------------------------------
	assign reqVec = {crcPend_r, r2mPend_r, m2rPend_r, loadPend_r};
	assign reqPage = {commitStore_r[spm_pkg::BIT_COMMIT_PAGE], commitStore_r[spm_pkg::BIT_COMMIT_PAGE],
		commitStore_r[spm_pkg::BIT_COMMIT_PAGE], pagePin_r};
	assign reqSkip = {3'h0, loadSkip_r};

	spm_mem_sequencer #(
		.NREQ(spm_pkg::NUM_OPS),
		.OW(spm_pkg::OP_W)
	) uSeq (
		.mclk(mclk),
		.rst_n(rst_n),
		.req(reqVec),
		.reqPage(reqPage),
		.reqSkip(reqSkip),
		.memBusy(memBusy),
		.grant(grant),
		.memStart(memStart),
		.memOp(memOp),
		.memPage(memPage),
		.memSkipCrc(memSkipCrc),
		.seqIdle(seqIdle)
	);

	// ----------------------------------------
	// Status pin routing.
	// ----------------------------------------
	spm_pin_router #(
		.NSRC(spm_pkg::NUM_SOURCES),
		.SW(spm_pkg::SEL_W),
		.NPIN(3)
	) uRouter (
		.mclk(mclk),
		.rst_n(rst_n),
		.statusSources(statusSources),
		.pinSel({pinSel_r[spm_pkg::PIN4_LSB +: spm_pkg::SEL_W], pinSel_r[spm_pkg::PIN1_LSB +: spm_pkg::SEL_W],
			pinSel_r[spm_pkg::PIN0_LSB +: spm_pkg::SEL_W]}),
		.pinOut(pinOut)
	);

	assign statusPinZero = pinOut[0];
	assign statusPinOne = pinOut[1];
	assign statusPinFour = pinOut[2];

	// ----------------------------------------
	// Read path.
	// ----------------------------------------
	// Command bits read as their pending state, so they fall to zero on acceptance.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			rdData_r <= spm_pkg::ZERO_WORD;
		else if (regRdEn)
		begin
			case (regAddr)
				spm_pkg::ADDR_PIN_SEL:
					rdData_r <= pinSel_r;
				spm_pkg::ADDR_COMMIT:
				begin
					rdData_r <= commitStore_r;
					rdData_r[spm_pkg::BIT_UPDATE_CRC] <= crcPend_r;
					rdData_r[spm_pkg::BIT_MEM_TO_REG] <= m2rPend_r;
					rdData_r[spm_pkg::BIT_REG_TO_MEM] <= r2mPend_r;
				end
				spm_pkg::ADDR_POWER:
					rdData_r <= powerReg_r;
				default:
					rdData_r <= spm_pkg::ZERO_WORD;
			endcase
		end
	end

	assign regRdData = rdData_r;

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	a_pin0_reset_code: assert property (@(posedge mclk) $rose(rst_n) |-> pinSel_r[11:8] == 4'h0)
		else $error("pin zero selector reset code wrong");
	a_pin4_reset_code: assert property (@(posedge mclk) $rose(rst_n) |-> pinSel_r[7:4] == 4'h5)
		else $error("pin four selector reset code wrong");
	a_pin1_reset_code: assert property (@(posedge mclk) $rose(rst_n) |-> pinSel_r[3:0] == 4'h3)
		else $error("pin one selector reset code wrong");
	a_power_reset_value: assert property (@(posedge mclk) $rose(rst_n) |-> powerReg_r == 16'h0054)
		else $error("power register reset value wrong");
	a_channel_write_follow: assert property (@(posedge mclk) disable iff (!rst_n)
		wrPower |=> channel1PowerOff == $past(regWrData[1]) && channel4PowerOff == $past(regWrData[7]))
		else $error("channel power bits did not follow write");
	a_skip_after_reset: assert property (@(posedge mclk) disable iff (!rst_n)
		resetLoadReq && !porLoadReq && commitStore_r[15] |=> loadSkip_r && loadPend_r)
		else $error("reset load did not bypass checksum");
	a_por_checks_page: assert property (@(posedge mclk) disable iff (!rst_n)
		porLoadReq && pageChosen |=> !loadSkip_r && loadPend_r)
		else $error("power-on load skipped checksum with page chosen");
	a_crc_launch: assert property (@(posedge mclk) disable iff (!rst_n)
		seqIdle && !memBusy && crcPend_r && !loadPend_r && !m2rPend_r && !r2mPend_r
		|=> memStart && memOp == 2'h3)
		else $error("checksum recompute not launched");
	a_load_page_launch: assert property (@(posedge mclk) disable iff (!rst_n)
		seqIdle && !memBusy && m2rPend_r && !loadPend_r |=> memStart && memOp == 2'h1)
		else $error("page to register not launched");
	a_store_page_launch: assert property (@(posedge mclk) disable iff (!rst_n)
		seqIdle && !memBusy && r2mPend_r && !loadPend_r && !m2rPend_r |=> memStart && memOp == 2'h2)
		else $error("register to page not launched");
	a_commit_page_used: assert property (@(posedge mclk) disable iff (!rst_n)
		memStart && memOp != 2'h0 |-> memPage == $past(commitStore_r[11]))
		else $error("commit used wrong page");
	a_boot_page_pin: assert property (@(posedge mclk) disable iff (!rst_n)
		memStart && memOp == 2'h0 |-> memPage == $past(pagePin_r))
		else $error("configuration load used wrong page");
	a_cmd_reads_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		memStart && memOp == 2'h3 && !(wrCommit && regWrData[14])
		|=> !crcPend_r ##1 (!crcPend_r || $past(wrCommit && regWrData[14])))
		else $error("accepted command still pending");
endmodule : spm_regs_top
`default_nettype wire

// [dv/spm_mem_model.sv]
/*
 Behavioural memory engine that answers start pulses with a busy level.
 Assumes starts arrive on mclk as one-cycle pulses from the register slice.
*/
`timescale 1ns/1ps
`default_nettype none
module spm_mem_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic memStart,
	input wire logic slow,
	output logic memBusy
);
	int remain; // Busy cycles still to run.
	// ----------------------------------------
	// Busy level.
	// ----------------------------------------
	// Busy rises at the edge after a start, inside the one-cycle allowance.
	// A slow job holds busy long enough for several register accesses to pass.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			remain <= 0;
			memBusy <= 1'b0;
		end
		else if (memStart)
		begin
			memBusy <= 1'b1;
			remain <= slow ? 40 : 3;
		end
		else if (remain > 1)
			remain <= remain - 1;
		else
		begin
			remain <= 0;
			memBusy <= 1'b0;
		end
	end
endmodule : spm_mem_model
`default_nettype wire

// [dv/testbench.sv]
/*
 Self-checking bench for the status pin and memory commit register slice.
 Assumes the engine model in spm_mem_model.sv on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk = 1'b0; // 125 MHz bench clock.
	logic rst_n = 1'b0; // Synchronous reset, active low.
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [spm_pkg::ADDR_W-1:0] regAddr = 8'h00;
	logic [spm_pkg::DATA_W-1:0] regWrData = 16'h0000;
	logic [spm_pkg::DATA_W-1:0] regRdData;
	logic [14:0] statusSources = 15'h0000;
	logic [14:0] pat; // Source pattern under test.
	logic externalPageSelectPin = 1'b1; // Strap differs from the page bit on purpose.
	logic resetLoadReq = 1'b0;
	logic porLoadReq = 1'b0;
	logic pageChosen = 1'b0;
	logic slow = 1'b0; // Makes the engine model hold busy longer.
	logic memBusy;
	logic memStart;
	logic memPage;
	logic memSkipCrc;
	logic [1:0] memOp;
	logic pin0;
	logic pin1;
	logic pin4;
	logic [3:0] chOff; // Channel four down to one.
	int bad_count = 0;
	int tests_run = 0;
	always #4 mclk = ~mclk;
	spm_regs_top u_spm_regs_top (.mclk(mclk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .statusSources(statusSources),
		.externalPageSelectPin(externalPageSelectPin), .resetLoadReq(resetLoadReq), .porLoadReq(porLoadReq),
		.pageChosen(pageChosen), .memBusy(memBusy), .memStart(memStart), .memOp(memOp), .memPage(memPage),
		.memSkipCrc(memSkipCrc), .statusPinZero(pin0), .statusPinOne(pin1), .statusPinFour(pin4),
		.channel1PowerOff(chOff[0]), .channel2PowerOff(chOff[1]), .channel3PowerOff(chOff[2]),
		.channel4PowerOff(chOff[3]));
	spm_mem_model u_spm_mem_model (.mclk(mclk), .rst_n(rst_n), .memStart(memStart), .slow(slow),
		.memBusy(memBusy));
	// ----------------------------------------
	// Check and access tasks.
	// ----------------------------------------
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// A write holds its strobe for one edge, then leaves one idle edge so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge mclk);
		regWrEn = 1'b0;
		@(negedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge mclk);
		regRdEn = 1'b0;
		chk(what, exp, regRdData);
		@(negedge mclk);
	endtask : rd
	// Waits, bounded, for a start pulse and checks what it launches.
	task automatic waitStart(input logic [1:0] op, input logic pg);
		int n;
		n = 0;
		while (memStart !== 1'b1 && n < 80)
		begin
			@(negedge mclk);
			n++;
		end
		if (memStart !== 1'b1)
		begin
			bad_count++;
			$display("[ERR] memStart expected 1 seen 0");
			close_out();
		end
		chk("memOp", {14'h0, op}, {14'h0, memOp});
		chk("memPage", {15'h0, pg}, {15'h0, memPage});
	endtask : waitStart
	// Software must see busy low before reading results; waits for the engine to finish.
	task automatic waitIdle;
		int n;
		n = 0;
		repeat (2) @(negedge mclk);
		while (memBusy !== 1'b0 && n < 80)
		begin
			@(negedge mclk);
			n++;
		end
		if (memBusy !== 1'b0)
		begin
			bad_count++;
			$display("[ERR] memBusy expected 0 seen 1");
			close_out();
		end
	endtask : waitIdle
	task automatic load(input logic por, input logic chosen, input logic expSkip);
		pageChosen = chosen;
		porLoadReq = por;
		resetLoadReq = ~por;
		@(negedge mclk);
		porLoadReq = 1'b0;
		resetLoadReq = 1'b0;
		waitStart(2'h0, 1'b1);
		chk("memSkipCrc", {15'h0, expSkip}, {15'h0, memSkipCrc});
		waitIdle();
	endtask : load
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		rd(8'h02, 16'h0053, "selector reset");
		rd(8'h03, 16'h0000, "commit reset");
		rd(8'h04, 16'h0054, "power reset");
		rd(8'h05, 16'h0000, "unmapped read");
		$display("test reset values done");
		wr(8'h04, 16'h00AA);
		chk("channels off", 16'h000F, {12'h0, chOff});
		wr(8'h04, 16'h0082);
		chk("channels mix", 16'h0009, {12'h0, chOff});
		rd(8'h04, 16'h0082, "power readback");
		$display("test power done");
		// Each code of pin zero is tried; pin four takes shifted codes and pin one reversed codes at the same time.
		for (int c = 0; c < 15; c++)
		begin
			wr(8'h02, {4'h0, 4'(c), 4'((c + 7) % 15), 4'(14 - c)});
			for (int inv = 0; inv < 2; inv++)
			begin
				pat = 15'h2AAA ^ {15{inv[0]}};
				statusSources = pat;
				repeat (8) @(negedge mclk);
				chk("pin zero", {15'h0, pat[c]}, {15'h0, pin0});
				chk("pin four", {15'h0, pat[(c + 7) % 15]}, {15'h0, pin4});
				chk("pin one", {15'h0, pat[14 - c]}, {15'h0, pin1});
			end
		end
		wr(8'h02, 16'h0FFF);
		statusSources = 15'h7FFF;
		repeat (8) @(negedge mclk);
		chk("unused code", 16'h0000, {13'h0, pin0, pin4, pin1});
		$display("test status pins done");
		slow = 1'b1;
		wr(8'h03, 16'h3800);
		waitStart(2'h1, 1'b1);
		// The pending flag drops at the edge after the start pulse rises, so the read waits one cycle.
		@(negedge mclk);
		rd(8'h03, 16'h1800, "commit pending");
		waitIdle();
		waitStart(2'h2, 1'b1);
		waitIdle();
		rd(8'h03, 16'h0800, "commit cleared");
		// Plain bits store; reserved bits 2-1 clear themselves one cycle after the write.
		wr(8'h03, 16'h07FF);
		rd(8'h03, 16'h07F9, "reserved self clear");
		slow = 1'b0;
		wr(8'h03, 16'h1000);
		waitStart(2'h2, 1'b0);
		waitIdle();
		wr(8'h03, 16'h4000);
		waitStart(2'h3, 1'b0);
		waitIdle();
		rd(8'h03, 16'h0000, "checksum cleared");
		$display("test commits done");
		wr(8'h03, 16'h8000);
		rd(8'h03, 16'h8000, "bypass stored");
		load(1'b0, 1'b1, 1'b1);
		load(1'b1, 1'b1, 1'b0);
		load(1'b1, 1'b0, 1'b1);
		wr(8'h03, 16'h0000);
		load(1'b0, 1'b0, 1'b0);
		$display("test loads done");
		close_out();
	end
endmodule : testbench
`default_nettype wire
